/* logic/usb_frame_timing_counters.sv */
// frame remaining down counter, toggle copy and frame number counter of a usb host core
// Overview of operation
// R01: a 14-bit down counter holds the bit times left in the frame, read in the low bits.
// R02: the counter steps down by one on each bit time and sits in bits 13 to 0.
// R03: at zero it reloads from the interval period length on the next bit-time boundary.
// R04: each time it reaches zero the interval toggle is copied into bit 31 of the register.
// R05: entering run reloads the counter from the period length, new values apply from next frame.
// R06: the frame number steps up on every reload and shows in bits 13 to 0.
// R07: the frame number rolls over to zero after ffff.
// R08: the frame number steps up once when the run state is entered.
// R09: the new frame number goes to the host area after the start token, before descriptor fetch.
// R10: after that write completes the start-of-frame status bit 2 is set.
// R11: software writes reserved bits of both registers as zero only.
// R12: software may extend the frame number to a 32-bit count of its own.
// R13: software may compare toggle copy and interval toggle to see a new period take effect.
// R14: software inverts the interval toggle whenever it writes a new period length.
// R15: the period length is 14 bits of bit times with a nominal reset value of 11999.
// R16: one bit-time tick is derived from the 12 Mbit/s rate and drives counter and reload.
`timescale 1ns/1ps
`default_nettype none
`include "frame_timing_map.svh"

module usb_frame_timing_counters #(
  parameter int CORE_MHZ = `CORE_MHZ,
  parameter int BIT_RATE_MHZ = `BIT_RATE_MHZ
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run_state,
  input wire logic [13:0] period_length,
  input wire logic interval_toggle,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic sof_sent,
  output logic hca_wr_req,
  output logic [15:0] hca_wr_data,
  input wire logic hca_wr_done,
  output logic desc_fetch_allow,
  output logic sof_status_set,
  output logic bit_tick
);

  if (BIT_RATE_MHZ < 1 || BIT_RATE_MHZ >= CORE_MHZ || CORE_MHZ >= (1 << `BIT_ACC_W)) begin : g_rate_check
    $error("bit rate must be below core rate and core rate must fit the accumulator");
  end

  localparam logic [`BIT_ACC_W-1:0] ACC_STEP = `BIT_ACC_W'(BIT_RATE_MHZ);
  localparam logic [`BIT_ACC_W-1:0] ACC_WRAP = `BIT_ACC_W'(CORE_MHZ);

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  logic [`BIT_ACC_W-1:0] acc_ff;
  logic [`BIT_ACC_W-1:0] nxt_acc;
  logic tick_ff;
  frame_timing_pkg::bit_count_type left_ff;
  logic toggle_copy_ff;
  frame_timing_pkg::sof_count_type sof_count_ff;
  frame_timing_pkg::frame_state_type state_ff;
  logic run_d_ff;
  logic run_entry;
  logic reload;
  logic wr_left;
  logic wr_count;
  logic sof_status_ff;
  logic req_ff;
  logic [15:0] hca_data_ff;

  // R16 fractional tick
  // accumulator keeps the average tick rate exact although 250/12 is not whole
  always_comb begin
    nxt_acc = acc_ff + ACC_STEP;
    if (nxt_acc >= ACC_WRAP) begin
      nxt_acc = nxt_acc - ACC_WRAP;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      tick_ff <= (acc_ff + ACC_STEP) >= ACC_WRAP;
    end
  end

  assign bit_tick = tick_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      run_d_ff <= 1'b0;
    end else begin
      run_d_ff <= run_state;
    end
  end

  assign run_entry = run_state && !run_d_ff;
  // R03 reload at boundary
  assign reload = run_state && run_d_ff && tick_ff && (left_ff == '0);
  assign wr_left = reg_wr && addr_hit(reg_addr, `TIME_LEFT_OFS);
  assign wr_count = reg_wr && addr_hit(reg_addr, `SOF_COUNTER_OFS);

  // bit-time-left down counter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      left_ff <= `TIME_LEFT_RESET;
    end else if (run_entry) begin
      // R05 reload on run entry
      // R15 14-bit period of bit times
      left_ff <= period_length;
    end else if (reload) begin
      // R03 load period length
      left_ff <= period_length;
    end else if (run_state && tick_ff) begin
      // R02 one per bit time
      left_ff <= left_ff - 14'h0001;
    end else if (wr_left) begin
      // write sticks unless run entry, a reload or a running tick falls in the same cycle; the counter wins then
      // R01 software visible value
      left_ff <= reg_wdata[`CNT_MSB:0];
    end
  end

  // toggle copy follows the interval toggle at each zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      toggle_copy_ff <= 1'b0;
    end else if (reload || run_entry) begin
      // R04 copy toggle
      toggle_copy_ff <= interval_toggle;
    end else if (wr_left) begin
      toggle_copy_ff <= reg_wdata[`TOGGLE_BIT];
    end
  end

  // frame number counter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sof_count_ff <= `SOF_COUNT_RESET;
    end else if (reload || run_entry) begin
      // R06 R08 step on reload or run entry
      // R07 wraps from ffff to zero
      sof_count_ff <= (sof_count_ff == `SOF_CNT_MAX) ? 16'h0000 : sof_count_ff + 16'h0001;
    end else if (wr_count) begin
      // bits 15:14 hidden from software, kept so the host area sees all 16
      sof_count_ff <= {sof_count_ff[15:14], reg_wdata[`CNT_MSB:0]};
    end
  end

  // frame boundary sequence: start token, host area write, then descriptor fetch
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= frame_timing_pkg::seq_idle;
      req_ff <= 1'b0;
      hca_data_ff <= '0;
      sof_status_ff <= 1'b0;
    end else begin
      sof_status_ff <= 1'b0;
      if (!run_state) begin
        state_ff <= frame_timing_pkg::seq_idle;
        req_ff <= 1'b0;
      end else if (reload || run_entry) begin
        // a new boundary restarts the sequence even if the last one hung
        state_ff <= frame_timing_pkg::seq_wait_sof;
        req_ff <= 1'b0;
      end else begin
        case (state_ff)
          frame_timing_pkg::seq_idle: begin
            state_ff <= frame_timing_pkg::seq_idle;
          end
          frame_timing_pkg::seq_wait_sof: begin
            // R09 write after token
            if (sof_sent) begin
              state_ff <= frame_timing_pkg::seq_write;
              req_ff <= 1'b1;
              hca_data_ff <= sof_count_ff;
            end
          end
          frame_timing_pkg::seq_write: begin
            if (hca_wr_done) begin
              state_ff <= frame_timing_pkg::seq_open;
              req_ff <= 1'b0;
              // R10 status after write
              sof_status_ff <= 1'b1;
            end
          end
          frame_timing_pkg::seq_open: begin
            state_ff <= frame_timing_pkg::seq_open;
          end
          default: begin
            state_ff <= frame_timing_pkg::seq_idle;
            req_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  assign hca_wr_req = req_ff;
  assign hca_wr_data = hca_data_ff;
  assign sof_status_set = sof_status_ff;
  // R09 descriptors only after the write
  assign desc_fetch_allow = (state_ff == frame_timing_pkg::seq_open);

  // reserved bits read as zero
  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (addr_hit(reg_addr, `TIME_LEFT_OFS)) begin
      reg_rdata[`TOGGLE_BIT] = toggle_copy_ff;
      reg_rdata[`CNT_MSB:0] = left_ff;
    end else if (addr_hit(reg_addr, `SOF_COUNTER_OFS)) begin
      reg_rdata[`CNT_MSB:0] = sof_count_ff[`CNT_MSB:0];
    end
  end

endmodule : usb_frame_timing_counters

`default_nettype wire

/* logic/frame_timing_map.svh */
// register offsets, field positions and timing figures of the frame timing counters
`ifndef FRAME_TIMING_MAP_SVH
`define FRAME_TIMING_MAP_SVH

`define TIME_LEFT_OFS 8'h38
`define SOF_COUNTER_OFS 8'h3c
`define ADDR_W 8

`define CNT_W 14
`define CNT_MSB 13
`define TOGGLE_BIT 31
`define SOF_CNT_W 16
`define SOF_CNT_MAX 16'hffff

`define PERIOD_RESET 14'h2edf
`define TIME_LEFT_RESET 14'h0000
`define SOF_COUNT_RESET 16'h0000

`define SOF_STATUS_BIT 2

`define CORE_MHZ 250
`define BIT_RATE_MHZ 12
`define BIT_ACC_W 9

`endif

/* logic/frame_timing_pkg.sv */
// types shared by the frame timing counters
package frame_timing_pkg;

  typedef enum logic [1:0] {
    seq_idle,
    seq_wait_sof,
    seq_write,
    seq_open
  } frame_state_type;

  typedef logic [13:0] bit_count_type;
  typedef logic [15:0] sof_count_type;

endpackage : frame_timing_pkg

/* tb/frame_timing_checker_asserts.sv */
// port-level checks of the frame timing counters
`timescale 1ns/1ps
`default_nettype none
module frame_timing_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run_state,
  input wire logic [13:0] period_length,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_rdata,
  input wire logic sof_sent,
  input wire logic hca_wr_req,
  input wire logic hca_wr_done,
  input wire logic desc_fetch_allow,
  input wire logic sof_status_set,
  input wire logic bit_tick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic on_left;
  logic step;
  assign on_left = reg_addr == 8'h38 && !reg_wr;
  assign step = run_state && bit_tick && on_left;
  chk_run_load:
  assert property ($rose(run_state) ##1 on_left |-> reg_rdata[13:0] == $past(period_length))
    else $error("counter not loaded on run entry");
  chk_dec_step:
  assert property (step && $past(run_state) && reg_rdata[13:0] != 14'h0 ##1 on_left
    |-> reg_rdata[13:0] == $past(reg_rdata[13:0]) - 14'h1) else $error("no decrement");
  chk_zero_reload:
  assert property (step && $past(run_state) && reg_rdata[13:0] == 14'h0 ##1 on_left
    |-> reg_rdata[13:0] == $past(period_length)) else $error("no reload at zero");
  chk_hca_after_sof:
  assert property ($rose(hca_wr_req) |-> $past(sof_sent)) else $error("write before sof");
  chk_fetch_waits:
  assert property (hca_wr_req |-> !desc_fetch_allow) else $error("fetch before write");
  chk_done_status:
  assert property (hca_wr_req && hca_wr_done
    |=> !hca_wr_req && sof_status_set && desc_fetch_allow)
    else $error("status not set after write");
  chk_status_cause:
  assert property ($rose(sof_status_set) |-> $past(hca_wr_req && hca_wr_done))
    else $error("status without write");
  chk_tick_pulse:
  assert property (bit_tick |=> !bit_tick) else $error("tick longer than one cycle");
endmodule : frame_timing_checker
bind usb_frame_timing_counters frame_timing_checker u_chk (.core_clk, .rstn, .run_state,
  .period_length, .reg_addr, .reg_wr, .reg_rdata, .sof_sent, .hca_wr_req, .hca_wr_done,
  .desc_fetch_allow, .sof_status_set, .bit_tick);
`default_nettype wire

/* tb/usb_frame_timing_counters_tb.sv */
// self-checking bench for the frame timing counters
`timescale 1ns/1ps
`default_nettype none
module usb_frame_timing_counters_tb;
  logic core_clk, rstn, run_state, interval_toggle, reg_wr, sof_sent, hca_wr_done, rd_en;
  logic hca_wr_req, desc_fetch_allow, sof_status_set, bit_tick;
  logic [13:0] period_length;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] hca_wr_data;
  logic [31:0] exp_q[$], msk_q[$];
  logic [15:0] hca_q[$];
  int n_fail, compares, seed, i;
  // small rates give a tick every second cycle, keeping frames short
  usb_frame_timing_counters #(.CORE_MHZ(4), .BIT_RATE_MHZ(2)) u_dut (.core_clk, .rstn,
    .run_state, .period_length, .interval_toggle, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .sof_sent, .hca_wr_req, .hca_wr_data, .hca_wr_done, .desc_fetch_allow, .sof_status_set,
    .bit_tick);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic bad;
    n_fail++;
    close_out();
  endtask : bad
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    reg_addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  // one host-area handshake; status and fetch allow must both be high the cycle after done
  task automatic frame(input logic [15:0] e);
    hca_q.push_back(e);
    sof_sent <= 1'b1;
    @(posedge core_clk);
    sof_sent <= 1'b0;
    for (i = 0; i < 20 && hca_wr_req !== 1'b1; i++) @(posedge core_clk);
    if (i == 20) bad();
    hca_wr_done <= 1'b1;
    @(posedge core_clk);
    hca_wr_done <= 1'b0;
    @(posedge core_clk);
    check({31'h0, sof_status_set & desc_fetch_allow}, 32'h1, "sof_status_set");
  endtask : frame
  always @(posedge core_clk) begin
    if (rd_en) check(reg_rdata & msk_q.pop_front(), exp_q.pop_front(), "reg_rdata");
    if (hca_wr_req && hca_q.size() > 0) check({16'h0, hca_wr_data}, hca_q.pop_front(), "hca");
  end
  initial begin
    #100000;
    bad();
  end
  initial begin
    seed = 57;
    {rstn, run_state, interval_toggle, reg_wr, sof_sent, hca_wr_done, rd_en} = '0;
    period_length = 14'h0008;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd(8'h38, 32'h0, 32'hffff_ffff);
    rd(8'h3c, 32'h0, 32'hffff_ffff);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    wr(8'h3c, 32'h0000_3fff);
    rd(8'h3c, 32'h0000_3fff, 32'hffff_ffff);
    period_length <= 14'h0008 + 14'($random(seed) & 15);
    interval_toggle <= 1'b1;
    run_state <= 1'b1;
    @(posedge core_clk);
    rd(8'h38, {1'b1, 17'h0, period_length}, 32'hffff_ffff);
    // low bits wrap because only 13:0 were written
    rd(8'h3c, 32'h0, 32'hffff_ffff);
    frame(16'h4000);
    for (int f = 1; f < 4; f++) begin
      period_length <= 14'h0008 + 14'($random(seed) & 15);
      interval_toggle <= ~f[0];
      for (i = 0; i < 200 && desc_fetch_allow !== 1'b0; i++) @(posedge core_clk);
      if (i == 200) bad();
      // toggle copy shows the new period took hold
      rd(8'h38, {~f[0], 17'h0, period_length}, 32'hffff_ffff);
      // bench keeps its own running frame count
      frame(16'h4000 + 16'(f));
    end
    close_out();
  end
endmodule : usb_frame_timing_counters_tb
`default_nettype wire
